// >>> pkg/cfg_port_pkg.sv
// constants and types for the configuration register access port
package cfg_port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int addr_width            = 24;
  localparam int data_width            = 32;
  localparam int axil_data_width_param = 32;
  localparam int index_width           = 14;

  // ----------------------------------------------------------------
  // address field positions
  // ----------------------------------------------------------------
  localparam int quad_msb  = 21;
  localparam int quad_lsb  = 20;
  localparam int block_msb = 18;
  localparam int block_lsb = 16;
  localparam int index_msb = 15;
  localparam int index_lsb = 2;

  // ----------------------------------------------------------------
  // quad and register block codes
  // ----------------------------------------------------------------
  localparam logic [1:0] quad_0                      = 2'h0;
  localparam logic [1:0] quad_1                      = 2'h1;
  localparam logic [2:0] blk_func_0                  = 3'h0;
  localparam logic [2:0] blk_func_1                  = 3'h1;
  localparam logic [2:0] blk_core                    = 3'h4;
  localparam logic [2:0] blk_phy_pll_control_block   = 3'h5;
  localparam logic [2:0] blk_lane_0                  = 3'h6;
  localparam logic [2:0] blk_lane_1                  = 3'h7;

  // ----------------------------------------------------------------
  // responses and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  resp_okay   = 2'h0;
  localparam logic [1:0]  resp_slverr = 2'h2;
  localparam logic [31:0] rst_data    = 32'h0000_0000;
  localparam logic [23:0] rst_addr    = 24'h00_0000;

  // port sequencer states
  typedef enum logic [1:0] {
    port_idle  = 2'b00,
    port_wait  = 2'b01,
    port_reply = 2'b10
  } port_state_type;

  // axi front end states
  typedef enum logic [2:0] {
    ax_idle  = 3'b000,
    ax_wacc  = 3'b001,
    ax_racc  = 3'b010,
    ax_wait  = 3'b011,
    ax_bresp = 3'b100,
    ax_rresp = 3'b101
  } axil_state_type;

endpackage

// >>> pkg/cfg_req_if.sv
// native request bundle between the axi front end and the port
`timescale 1ns/10ps
interface cfg_req_if;
  import cfg_port_pkg::*;
  logic                  req;   // start request
  logic                  wr;    // 1 write, 0 read
  logic [addr_width-1:0] addr;  // byte address
  logic [data_width-1:0] wdata; // write data
  logic                  ready; // port can take a request
  logic                  done;  // one-cycle completion
  logic                  err;   // completion hit a reserved target
  logic [data_width-1:0] rdata; // read data, valid with done
  modport master (output req, wr, addr, wdata,
                  input  ready, done, err, rdata);
  modport target (input  req, wr, addr, wdata,
                  output ready, done, err, rdata);
endinterface

// >>> core/axil_front.sv
// axi4-lite subordinate that feeds the native request port
`timescale 1ns/10ps
module axil_front
  import cfg_port_pkg::*;
#(
  parameter bit axil_enable = 1'b1
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // write address and data
  input  wire logic                  awvalid,
  input  wire logic [addr_width-1:0] awaddr,
  output logic                       awready,
  input  wire logic                  wvalid,
  input  wire logic [data_width-1:0] wdata,
  output logic                       wready,
  // write response
  input  wire logic                  bready,
  output logic                       bvalid,
  output logic [1:0]                 bresp,
  // read address and data
  input  wire logic                  arvalid,
  input  wire logic [addr_width-1:0] araddr,
  output logic                       arready,
  input  wire logic                  rready,
  output logic                       rvalid,
  output logic [data_width-1:0]      rdata,
  output logic [1:0]                 rresp,
  // native request side
  cfg_req_if.master                  bus
);

  axil_state_type        state_r, state_nxt;
  logic                  awready_r, wready_r, arready_r;
  logic                  bvalid_r, rvalid_r, req_r, wr_r;
  logic [1:0]            bresp_r, rresp_r;
  logic [data_width-1:0] rdata_r, wdata_r;
  logic [addr_width-1:0] addr_r;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire       wr_go   = axil_enable && awvalid && wvalid;
  wire       rd_go   = axil_enable && arvalid && !wr_go;
  wire       started = req_r && bus.ready;
  wire [1:0] resp_w  = bus.err ? resp_slverr : resp_okay;

  // next state; only idle admits a new address
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ax_idle:  if (wr_go) state_nxt = ax_wacc;
                else if (rd_go) state_nxt = ax_racc;
      ax_wacc:  state_nxt = ax_wait;
      ax_racc:  state_nxt = ax_wait;
      ax_wait:  if (bus.done) state_nxt = wr_r ? ax_bresp : ax_rresp;
      ax_bresp: if (bready) state_nxt = ax_idle;
      ax_rresp: if (rready) state_nxt = ax_idle;
      default:  state_nxt = ax_idle;
    endcase
  end

  // state and channel handshakes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r   <= ax_idle;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      arready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      rvalid_r  <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      awready_r <= (state_nxt == ax_wacc);
      wready_r  <= (state_nxt == ax_wacc);
      arready_r <= (state_nxt == ax_racc);
      bvalid_r  <= (state_nxt == ax_bresp);
      rvalid_r  <= (state_nxt == ax_rresp);
    end
  end

  // one native request per accepted pair, held until taken
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_r   <= 1'b0;
      wr_r    <= 1'b0;
      addr_r  <= rst_addr;
      wdata_r <= rst_data;
    end
    else
    begin
      req_r <= (state_r == ax_wacc) || (state_r == ax_racc) ||
               (req_r && !started);
      if (state_r == ax_wacc)
      begin
        wr_r    <= 1'b1;
        addr_r  <= awaddr;
        wdata_r <= wdata;
      end
      else if (state_r == ax_racc)
      begin
        wr_r   <= 1'b0;
        addr_r <= araddr;
      end
    end
  end

  // response capture at native completion
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bresp_r <= resp_okay;
      rresp_r <= resp_okay;
      rdata_r <= rst_data;
    end
    else if (state_r == ax_wait && bus.done)
    begin
      if (wr_r) bresp_r <= resp_w;
      else
      begin
        rresp_r <= resp_w;
        rdata_r <= bus.rdata;
      end
    end
  end

  assign bus.req   = req_r;
  assign bus.wr    = wr_r;
  assign bus.addr  = addr_r;
  assign bus.wdata = wdata_r;
  assign awready   = awready_r;
  assign wready    = wready_r;
  assign arready   = arready_r;
  assign bvalid    = bvalid_r;
  assign bresp     = bresp_r;
  assign rvalid    = rvalid_r;
  assign rresp     = rresp_r;
  assign rdata     = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_one_at_time:
    assert property (state_r == ax_wait |-> !awready_r && !arready_r)
      else $error("address ready raised while busy");
  chk_single_req:
    assert property (started |=> !req_r [*2])
      else $error("native request repeated for one pair");
  chk_bresp_after:
    assert property (state_r == ax_wait && bus.done && wr_r |=> bvalid_r)
      else $error("write response not raised after completion");
  chk_axil_off:
    assert property (!axil_enable |-> !awready_r && !arready_r)
      else $error("axi port active while disabled");

endmodule // axil_front

// >>> core/cfg_access_port.sv
// configuration register access port with native and axi front ends
`timescale 1ns/10ps
module cfg_access_port
  import cfg_port_pkg::*;
#(
  parameter bit axil_enable = 1'b1
)
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // native request port
  input  wire logic                  cfg_req,
  input  wire logic                  cfg_wr,
  input  wire logic [addr_width-1:0] cfg_addr,
  input  wire logic [data_width-1:0] cfg_wdata,
  output logic                       cfg_ready,
  output logic                       cfg_rdata_valid,
  output logic [data_width-1:0]      cfg_rdata,
  // axi4-lite write channels
  input  wire logic                  axil_awvalid,
  input  wire logic [addr_width-1:0] axil_awaddr,
  input  wire logic [2:0]            axil_awprot,
  output logic                       axil_awready,
  input  wire logic                  axil_wvalid,
  input  wire logic [data_width-1:0] axil_wdata,
  input  wire logic [3:0]            axil_wstrb,
  output logic                       axil_wready,
  input  wire logic                  axil_bready,
  output logic                       axil_bvalid,
  output logic [1:0]                 axil_bresp,
  // axi4-lite read channels
  input  wire logic                  axil_arvalid,
  input  wire logic [addr_width-1:0] axil_araddr,
  input  wire logic [2:0]            axil_arprot,
  output logic                       axil_arready,
  input  wire logic                  axil_rready,
  output logic                       axil_rvalid,
  output logic [data_width-1:0]      axil_rdata,
  output logic [1:0]                 axil_rresp,
  // register block target side
  output logic                       tgt_req,
  output logic                       tgt_wr,
  output logic [1:0]                 tgt_quad,
  output logic [2:0]                 tgt_block,
  output logic [index_width-1:0]     tgt_index,
  output logic [data_width-1:0]      tgt_wdata,
  input  wire logic                  tgt_done,
  input  wire logic [data_width-1:0] tgt_rdata
);

  cfg_req_if axil_bus ();

  port_state_type         state_r, state_nxt;
  logic                   ready_r;         // internal ready
  logic                   cfg_ready_r;     // native pin ready
  logic                   done_r, err_r;   // completion to front end
  logic                   op_wr_r;         // direction of transfer
  logic                   cfg_rvalid_r;    // native read valid
  logic [data_width-1:0]  rdata_r;         // read data
  logic                   tgt_req_r, tgt_wr_r;
  logic [1:0]             tgt_quad_r;
  logic [2:0]             tgt_block_r;
  logic [index_width-1:0] tgt_index_r;
  logic [data_width-1:0]  tgt_wdata_r;

  // ----------------------------------------------------------------
  // axi front end
  // ----------------------------------------------------------------
  axil_front #(.axil_enable (axil_enable)) u_front (
    .clk     (clk),
    .resetn  (resetn),
    .awvalid (axil_awvalid),
    .awaddr  (axil_awaddr),
    .awready (axil_awready),
    .wvalid  (axil_wvalid),
    .wdata   (axil_wdata),
    .wready  (axil_wready),
    .bready  (axil_bready),
    .bvalid  (axil_bvalid),
    .bresp   (axil_bresp),
    .arvalid (axil_arvalid),
    .araddr  (axil_araddr),
    .arready (axil_arready),
    .rready  (axil_rready),
    .rvalid  (axil_rvalid),
    .rdata   (axil_rdata),
    .rresp   (axil_rresp),
    .bus     (axil_bus.master)
  );

  // ----------------------------------------------------------------
  // source select and address decode
  // ----------------------------------------------------------------
  // front end owns the port when built in
  wire                   sel_req   = axil_enable ? axil_bus.req : cfg_req;
  wire                   sel_wr    = axil_enable ? axil_bus.wr : cfg_wr;
  wire [addr_width-1:0]  sel_addr  = axil_enable ? axil_bus.addr : cfg_addr;
  wire [data_width-1:0]  sel_wdata = axil_enable ? axil_bus.wdata
                                                 : cfg_wdata;
  // start only on request with ready
  wire                   start_w   = sel_req && ready_r;
  // unused bits 23:22, 19, 1:0 are not decoded
  wire [1:0]             quad_w    = sel_addr[quad_msb:quad_lsb];
  wire [2:0]             blk_w     = sel_addr[block_msb:block_lsb];
  wire [index_width-1:0] idx_w     = sel_addr[index_msb:index_lsb];
  // quads 2 and 3 are not present yet
  wire                   quad_ok   = (quad_w == quad_0) ||
                                     (quad_w == quad_1);
  // block codes 3'h2 and 3'h3 lead nowhere
  wire                   blk_ok    = (blk_w == blk_func_0) ||
                                     (blk_w == blk_func_1) ||
                                     (blk_w == blk_core) ||
                                     (blk_w == blk_phy_pll_control_block) ||
                                     (blk_w == blk_lane_0) ||
                                     (blk_w == blk_lane_1);
  wire                   mapped_w  = quad_ok && blk_ok;
  // completion: target answered, or local reply to reserved target
  wire                   done_w    = (state_r == port_wait && tgt_done) ||
                                     (state_r == port_reply);
  wire                   rd_done_w = done_w && !op_wr_r;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one transfer in flight; reserved targets answered locally
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      port_idle:
        if (start_w) state_nxt = mapped_w ? port_wait : port_reply;
      port_wait:
        if (tgt_done) state_nxt = port_idle;
      port_reply:
        state_nxt = port_idle;
      default:
        state_nxt = port_idle;
    endcase
  end

  // state and ready; reset asserts at once, release follows clk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r     <= port_idle;
      ready_r     <= 1'b0;
      cfg_ready_r <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      ready_r     <= (state_nxt == port_idle);
      cfg_ready_r <= (state_nxt == port_idle) && !axil_enable;
    end
  end

  // target request pulse and captured fields
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tgt_req_r   <= 1'b0;
      tgt_wr_r    <= 1'b0;
      op_wr_r     <= 1'b0;
      tgt_quad_r  <= quad_0;
      tgt_block_r <= blk_func_0;
      tgt_index_r <= '0;
      tgt_wdata_r <= rst_data;
    end
    else
    begin
      tgt_req_r <= start_w && mapped_w;
      if (start_w)
      begin
        op_wr_r     <= sel_wr;
        tgt_wr_r    <= sel_wr;
        tgt_quad_r  <= quad_w;
        tgt_block_r <= blk_w;
        tgt_index_r <= idx_w;
        tgt_wdata_r <= sel_wdata;
      end
    end
  end

  // completion and read data
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      done_r       <= 1'b0;
      err_r        <= 1'b0;
      cfg_rvalid_r <= 1'b0;
      rdata_r      <= rst_data;
    end
    else
    begin
      done_r       <= done_w;
      err_r        <= (state_r == port_reply);
      cfg_rvalid_r <= rd_done_w && !axil_enable;
      if (rd_done_w)
        rdata_r <= (state_r == port_reply) ? rst_data : tgt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axil_bus.ready  = ready_r;
  assign axil_bus.done   = done_r;
  assign axil_bus.err    = err_r;
  assign axil_bus.rdata  = rdata_r;
  assign cfg_ready       = cfg_ready_r;
  assign cfg_rdata_valid = cfg_rvalid_r;
  assign cfg_rdata       = rdata_r;
  assign tgt_req         = tgt_req_r;
  assign tgt_wr          = tgt_wr_r;
  assign tgt_quad        = tgt_quad_r;
  assign tgt_block       = tgt_block_r;
  assign tgt_index       = tgt_index_r;
  assign tgt_wdata       = tgt_wdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_reset_quiet:
    assert property (disable iff (1'b0)
      !resetn |=> !ready_r && !tgt_req_r && !cfg_rvalid_r && !done_r)
      else $error("outputs active right after reset");
  chk_start_handshake:
    assert property (tgt_req_r |-> $past(start_w))
      else $error("target request without handshake");
  chk_busy_throttle:
    assert property (start_w |=> !ready_r)
      else $error("ready stayed high after a start");
  chk_ready_return:
    assert property (done_r |-> ready_r)
      else $error("ready not back at completion");
  chk_rvalid_pulse:
    assert property (cfg_rvalid_r |=> !cfg_rvalid_r)
      else $error("read valid longer than one cycle");
  chk_rvalid_read:
    assert property (cfg_rvalid_r |-> done_r && !op_wr_r)
      else $error("read valid without a read completing");
  chk_reserved_local:
    assert property (start_w && !quad_ok |=> !tgt_req_r ##1 done_r && err_r)
      else $error("reserved quad reached a target");
  chk_block_route:
    assert property (tgt_req_r |->
      tgt_block_r == $past(blk_w) && tgt_quad_r == $past(quad_w))
      else $error("block or quad routed wrongly");
  chk_index_route:
    assert property (tgt_req_r |-> tgt_index_r == $past(idx_w))
      else $error("register index routed wrongly");

endmodule // cfg_access_port

// >>> tb/reg_block_model.sv
// stand-in for the register blocks behind the port's target side
`timescale 1ns/10ps
module reg_block_model
  import cfg_port_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // request from the port
  input  wire logic                   tgt_req,
  input  wire logic                   tgt_wr,
  input  wire logic [1:0]             tgt_quad,
  input  wire logic [2:0]             tgt_block,
  input  wire logic [index_width-1:0] tgt_index,
  input  wire logic [data_width-1:0]  tgt_wdata,
  // answer speed select
  input  wire logic                   slow,
  // completion back to the port
  output logic                        tgt_done,
  output logic [data_width-1:0]       tgt_rdata
);
  logic [data_width-1:0] mem [0:63]; // register storage
  logic [3:0]            wait_r;     // cycles left before done
  logic                  busy_r;     // request in flight
  logic [5:0]            key;        // storage slot of the request
  assign key = {tgt_quad[0], tgt_block, tgt_index[1:0]};
  // answer after one or eight cycles; idle read data keeps toggling
  always @(posedge clk)
  begin
    tgt_done  <= 1'b0;
    tgt_rdata <= ~tgt_rdata;
    if (!resetn)
    begin
      busy_r    <= 1'b0;
      tgt_rdata <= 32'h5a5a_a5a5;
    end
    else if (tgt_req)
    begin
      busy_r <= 1'b1;
      wait_r <= slow ? 4'h7 : 4'h0;
    end
    else if (busy_r && wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else if (busy_r)
    begin
      busy_r   <= 1'b0;
      tgt_done <= 1'b1;
      if (tgt_wr)
        mem[key] <= tgt_wdata;
      else
        tgt_rdata <= mem[key];
    end
  end
endmodule // reg_block_model

// >>> tb/tb_config_register_access_port.sv
// self-checking bench for the access port with the axi front end built in
`timescale 1ns/10ps
module tb_config_register_access_port;
  import cfg_port_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk, resetn, slow, cfg_req, cfg_wr, cfg_ready, cfg_rdata_valid;
  logic [addr_width-1:0] cfg_addr, axil_awaddr, axil_araddr;
  logic [data_width-1:0] cfg_wdata, cfg_rdata, axil_wdata, axil_rdata;
  logic [data_width-1:0] tgt_wdata, tgt_rdata;
  logic [2:0] axil_awprot, axil_arprot, tgt_block;
  logic [3:0] axil_wstrb;
  logic [1:0] axil_bresp, axil_rresp, tgt_quad;
  logic axil_awvalid, axil_awready, axil_wvalid, axil_wready, axil_bready;
  logic axil_bvalid, axil_arvalid, axil_arready, axil_rready, axil_rvalid;
  logic tgt_req, tgt_wr, tgt_done;
  logic [index_width-1:0] tgt_index;
  int bad_count, comparisons, req_seen, req_exp;
  // design under test and the register blocks behind it
  cfg_access_port #(.axil_enable(1'b1)) uut (.clk, .resetn, .cfg_req,
    .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_ready, .cfg_rdata_valid,
    .cfg_rdata, .axil_awvalid, .axil_awaddr, .axil_awprot, .axil_awready,
    .axil_wvalid, .axil_wdata, .axil_wstrb, .axil_wready, .axil_bready,
    .axil_bvalid, .axil_bresp, .axil_arvalid, .axil_araddr, .axil_arprot,
    .axil_arready, .axil_rready, .axil_rvalid, .axil_rdata, .axil_rresp,
    .tgt_req, .tgt_wr, .tgt_quad, .tgt_block, .tgt_index, .tgt_wdata,
    .tgt_done, .tgt_rdata);
  reg_block_model model (.clk, .resetn, .tgt_req, .tgt_wr, .tgt_quad,
    .tgt_block, .tgt_index, .tgt_wdata, .slow, .tgt_done, .tgt_rdata);
  // 125 MHz clock, shared with the axi side
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // counts target requests issued by the port
  always @(posedge clk)
    if (tgt_req === 1'b1)
      req_seen++;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // returns at the rising edge where sig is sampled high
  task automatic wait_hi(ref logic sig);
    for (int n = 0; n < 60; n++)
    begin
      @(posedge clk);
      if (sig === 1'b1)
        return;
    end
    bad_count++;
    $display("CHECK FAILED handshake wait expected 1 seen timeout");
    end_sim();
  endtask
  // address with unused bits held at zero
  function automatic logic [23:0] mk(logic [1:0] q, logic [2:0] b,
                                     logic [13:0] i);
    return {2'b00, q, 1'b0, b, i, 2'b00};
  endfunction
  task automatic axi_write(input logic [23:0] a, input logic [31:0] d,
                           input int stall, input logic [1:0] resp);
    @(negedge clk);
    axil_awaddr  = a;
    axil_wdata   = d;
    axil_awvalid = 1'b1;
    axil_wvalid  = 1'b1;
    wait_hi(axil_awready);
    check("wready", 1, axil_wready);
    @(negedge clk);
    axil_awvalid = 1'b0;
    axil_wvalid  = 1'b0;
    // response must stand while bready stays low
    wait_hi(axil_bvalid);
    repeat (stall) @(negedge clk);
    if (stall > 0)
      check("bvalid held", 1, axil_bvalid);
    @(negedge clk);
    axil_bready = 1'b1;
    wait_hi(axil_bvalid);
    check("bresp", resp, axil_bresp);
    @(negedge clk);
    axil_bready = 1'b0;
  endtask
  task automatic read_tail(input logic [31:0] d, input logic [1:0] resp);
    wait_hi(axil_arready);
    @(negedge clk);
    axil_arvalid = 1'b0;
    axil_rready  = 1'b1;
    wait_hi(axil_rvalid);
    check("rdata", d, axil_rdata);
    check("rresp", resp, axil_rresp);
    @(negedge clk);
    axil_rready = 1'b0;
  endtask
  task automatic axi_read(input logic [23:0] a, input logic [31:0] d,
                          input logic [1:0] resp);
    @(negedge clk);
    axil_araddr  = a;
    axil_arvalid = 1'b1;
    read_tail(d, resp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // quads 0 and 1 with each of the six mapped block codes reach the target with the index
  task automatic sc_decode();
    logic [2:0]  blk [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [13:0] ix;
    for (int q = 0; q < 2; q++)
      for (int j = 0; j < 6; j++)
      begin
        ix = q ? 14'h3ffc + 14'(j % 4) : 14'(j % 4);
        axi_write(mk(2'(q), blk[j], ix), 32'hc0de_0000 + 32'(q * 16 + j),
                  j, resp_okay);
        req_exp++;
        check("tgt_quad", 32'(q), 32'(tgt_quad));
        check("tgt_block", 32'(blk[j]), 32'(tgt_block));
        check("tgt_index", 32'(ix), 32'(tgt_index));
        check("tgt_wr", 1, tgt_wr);
      end
    for (int q = 0; q < 2; q++)
      for (int j = 0; j < 6; j++)
      begin
        ix = q ? 14'h3ffc + 14'(j % 4) : 14'(j % 4);
        axi_read(mk(2'(q), blk[j], ix), 32'hc0de_0000 + 32'(q * 16 + j),
                 resp_okay);
        req_exp++;
      end
  endtask
  // reserved quads and blocks never reach the target
  task automatic sc_reserved();
    logic [23:0] a [4];
    a = '{mk(2'h2, 3'h4, 0), mk(2'h3, 3'h4, 0), mk(0, 3'h2, 0),
          mk(0, 3'h3, 0)};
    for (int k = 0; k < 4; k++)
    begin
      axi_write(a[k], 32'hffff_ffff, 0, resp_slverr);
      axi_read(a[k], 32'h0000_0000, resp_slverr);
    end
  endtask
  // a read waiting behind a slow write is not taken early
  task automatic sc_serial();
    slow = 1'b1;
    @(negedge clk);
    axil_awaddr  = mk(1, 3'h5, 14'h0002);
    axil_wdata   = 32'h1234_5678;
    axil_awvalid = 1'b1;
    axil_wvalid  = 1'b1;
    wait_hi(axil_awready);
    @(negedge clk);
    axil_awvalid = 1'b0;
    axil_wvalid  = 1'b0;
    axil_araddr  = mk(1, 3'h5, 14'h0002);
    axil_arvalid = 1'b1;
    repeat (12)
    begin
      @(posedge clk);
      check("arready busy", 0, axil_arready);
    end
    @(negedge clk);
    axil_bready = 1'b1;
    wait_hi(axil_bvalid);
    @(negedge clk);
    axil_bready = 1'b0;
    read_tail(32'h1234_5678, resp_okay);
    req_exp += 2;
    slow = 1'b0;
  endtask
  // native port stays shut while the axi front end is built in
  task automatic sc_native();
    @(negedge clk);
    cfg_req  = 1'b1;
    cfg_addr = mk(0, 3'h4, 14'h0001);
    repeat (8)
    begin
      @(posedge clk);
      check("cfg_ready", 0, cfg_ready);
      check("cfg_rdata_valid", 0, cfg_rdata_valid);
    end
    check("cfg_rdata mirror", 32'h1234_5678, cfg_rdata);
    @(negedge clk);
    cfg_req = 1'b0;
  endtask
  // reset asserted mid-transfer clears the target fields at once
  task automatic sc_midreset();
    slow = 1'b1;
    @(negedge clk);
    axil_awaddr  = mk(1, 3'h7, 14'h0003);
    axil_awvalid = 1'b1;
    axil_wvalid  = 1'b1;
    wait_hi(axil_awready);
    @(negedge clk);
    axil_awvalid = 1'b0;
    axil_wvalid  = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b0;
    #1;
    check("tgt_block in reset", 0, 32'(tgt_block));
    check("tgt_quad in reset", 0, 32'(tgt_quad));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    slow   = 1'b0;
    repeat (10) @(negedge clk);
    req_exp++;
    axi_read(mk(0, 3'h4, 14'h0002), 32'hc0de_0002, resp_okay);
    req_exp++;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {resetn, slow, cfg_req, cfg_wr, cfg_addr, cfg_wdata} = '0;
    {axil_awvalid, axil_awaddr, axil_awprot, axil_wvalid} = '0;
    {axil_wdata, axil_bready, axil_arvalid, axil_araddr} = '0;
    {axil_arprot, axil_rready} = '0;
    axil_wstrb = 4'hf;
    {bad_count, comparisons, req_exp} = '0;
    repeat (6) @(negedge clk);
    check("awready in reset", 0, axil_awready);
    check("bvalid in reset", 0, axil_bvalid);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    sc_decode();
    sc_reserved();
    sc_serial();
    sc_native();
    sc_midreset();
    check("target requests", 32'(req_exp), 32'(req_seen));
    end_sim();
  end
endmodule // tb_config_register_access_port
